/* include/supervisor_pkg.sv */
// ****************************************************************
// Shared constants and types of the supply and reset supervisor
// ****************************************************************
package supervisor_pkg;

  // ****************************************************************
  // Register map (byte addresses on the AXI4-Lite port)
  // ****************************************************************
  localparam int ADDR_W = 4;                                 // Address bits decoded
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 4'h0;      // Supply integrity ctrl/status
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;       // Sticky event bits
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;         // Event mask

  // ****************************************************************
  // Field positions of the ctrl/status register
  // ****************************************************************
  localparam int BIT_IRQ_ENABLE = 0;                         // Supply-warning irq enable
  localparam int BIT_WARN_FLAG = 1;                          // Supply-warning flag
  localparam int BIT_UV_FLAG = 2;                            // Undervoltage cause flag
  localparam int BIT_PLL_LOCK = 3;                           // PLL lock flag
  localparam int BIT_WDG_FLAG = 4;                           // Watchdog cause flag

  // ****************************************************************
  // Field positions of the event status and mask registers
  // ****************************************************************
  localparam int EVT_WDG = 0;                                // Watchdog reset happened
  localparam int EVT_UV = 1;                                 // Undervoltage reset happened
  localparam int EVT_WARN = 2;                               // Supply-warning flag rose
  localparam int EVT_N = 3;                                  // Number of events

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [EVT_N-1:0] RST_IRQ_MASK = 3'h0;          // All events masked
  localparam logic RST_IRQ_ENABLE = 1'b0;                    // Warning interrupt off

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;                         // 20 MHz CPU clock
  localparam int WDG_PULSE_MIN_NS = 30000;                   // Least watchdog pulse on pin
  localparam int WDG_PULSE_CYC =
    (WDG_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // Rounded up
  localparam int DELAY_SHORT_CYC = 256;                      // Post-reset delay, RC/ext clk
  localparam int DELAY_LONG_CYC = 4096;                      // Post-reset delay, crystal
  localparam int CNT_W = 13;                                 // Counter width

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    LEVEL_LOW,
    LEVEL_MEDIUM,
    LEVEL_HIGH
  } threshold_level_t;

  typedef enum logic [2:0] {
    SEQ_IDLE,          // Line released, no reset in progress
    SEQ_WDG_PULSE,     // Watchdog pulse on the line
    SEQ_UV_HOLD,       // Undervoltage holds the line
    SEQ_EXT_HOLD,      // Another party holds the line
    SEQ_DELAY          // Post-reset delay, line held
  } seq_state_t;

  // ****************************************************************
  // AXI4-Lite carriers
  // ****************************************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;                   // Mapped access
  localparam logic [1:0] RESP_SLVERR = 2'h2;                 // Unmapped access

endpackage : supervisor_pkg

/* hdl/reset_supply_supervisor.sv */
// Functional notes
// - Watchdog underflow drives line low, minimum pulse
// - Undervoltage reset keeps shared line low
// - All sources act; line low during delay
// - Watchdog flag bit4; write-zero or undervoltage clears
// - PLL lock bit3 follows hardware only
// - Undervoltage flag bit2; set by reset, read clears
// - External/watchdog reset keep undervoltage flag
// - Two cause flags identify watchdog reset
// - Warning flag bit1 follows comparator, read-only
// - Enabled rising warning flag raises interrupt request
// - Request forwarded only when CPU unmasked
// - Enable bit0 writable; service entry clears pending
// - Warning detector works only with undervoltage enabled
// - Wait mode unaffected; warning wakes from wait
// - Halt freezes register; warning never wakes halt
// - Threshold level selectable; warning derived from it
`timescale 1ns/1ps
module reset_supply_supervisor #(
  parameter int WDG_PULSE_CYCLES = supervisor_pkg::WDG_PULSE_CYC,
  parameter int DELAY_SHORT = supervisor_pkg::DELAY_SHORT_CYC,
  parameter int DELAY_LONG = supervisor_pkg::DELAY_LONG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite register port
  input wire supervisor_pkg::axil_req_t bus_req,
  output supervisor_pkg::axil_rsp_t bus_rsp,
  // Configuration options
  input wire logic uv_detector_enable,
  input wire supervisor_pkg::threshold_level_t uv_level,
  input wire logic crystal_clock_source,
  // Reset sources and analog status
  input wire logic wdg_underflow,
  input wire logic uv_comparator,
  input wire logic warn_comparator_async,
  input wire logic pll_locked,
  // Open-drain reset line
  input wire logic reset_line_in,
  output logic reset_line_out,
  output logic reset_line_oe,
  output logic core_reset,
  // Threshold selection to the analog side
  output supervisor_pkg::threshold_level_t uv_threshold_sel,
  output supervisor_pkg::threshold_level_t warn_threshold_sel,
  // CPU interrupt interface
  input wire logic cpu_irq_masked,
  input wire logic warn_isr_enter,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic warn_irq_req,
  output logic wait_wakeup,
  // Event interrupt
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    supervisor_pkg::seq_state_t seq;                         // Reset line sequencer
    logic [supervisor_pkg::CNT_W-1:0] count;                 // Pulse and delay counter
    logic wdg_flag;                                          // Watchdog cause
    logic uv_flag;                                           // Undervoltage cause
    logic pll_lock;                                          // Captured lock status
    logic irq_enable;                                        // Warning irq enable
    logic warn_sync1;                                        // First synchroniser stage
    logic warn_sync2;                                        // Second synchroniser stage
    logic warn_flag;                                         // Visible warning flag
    logic warn_pend;                                         // Pending warning request
    logic [supervisor_pkg::EVT_N-1:0] evt_status;            // Sticky events
    logic [supervisor_pkg::EVT_N-1:0] evt_mask;              // Event mask
    logic bvalid;                                            // Write response pending
    logic [1:0] bresp;                                       // Write response code
    logic rvalid;                                            // Read data pending
    logic [31:0] rdata;                                      // Read data
    logic [1:0] rresp;                                       // Read response code
  } state_t;

  state_t s;       // Registered state
  state_t next_s;  // Next state

  // Counter loads, cut to the counter width on purpose
  localparam logic [supervisor_pkg::CNT_W-1:0] WDG_LOAD =
    supervisor_pkg::CNT_W'(WDG_PULSE_CYCLES - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] SHORT_LOAD =
    supervisor_pkg::CNT_W'(DELAY_SHORT - 1);
  localparam logic [supervisor_pkg::CNT_W-1:0] LONG_LOAD =
    supervisor_pkg::CNT_W'(DELAY_LONG - 1);

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  logic wr_go;                                               // Write address and data taken
  logic rd_go;                                               // Read address taken
  logic [7:0] csr_view;                                      // Ctrl/status read value
  logic [supervisor_pkg::CNT_W-1:0] delay_load;              // Delay chosen by clock source

  // Both write channels are taken together; this keeps one decode path
  assign wr_go = bus_req.awvalid & bus_req.wvalid & ~s.bvalid;
  assign rd_go = bus_req.arvalid & ~s.rvalid;
  assign delay_load = crystal_clock_source ? LONG_LOAD : SHORT_LOAD;

  // Cause flags at bits 4 and 2 together tell a watchdog reset apart
  assign csr_view = {3'h0, s.wdg_flag, s.pll_lock, s.uv_flag, s.warn_flag, s.irq_enable};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s = s;

    // Clear on read comes first, so that an event of this cycle survives it
    if (rd_go && bus_req.araddr == supervisor_pkg::OFS_IRQ_STATUS) begin
      next_s.evt_status = '0;
    end

    // Synchroniser; only the second stage is read below
    next_s.warn_sync1 = warn_comparator_async;
    next_s.warn_sync2 = s.warn_sync1;

    // Reset line sequencer; undervoltage has the highest priority
    if (uv_detector_enable && uv_comparator && s.seq != supervisor_pkg::SEQ_UV_HOLD) begin
      next_s.seq = supervisor_pkg::SEQ_UV_HOLD;
      next_s.uv_flag = 1'b1;
      next_s.wdg_flag = 1'b0;
      next_s.evt_status[supervisor_pkg::EVT_UV] = 1'b1;
    end else begin
      unique case (s.seq)
        supervisor_pkg::SEQ_IDLE: begin
          if (wdg_underflow) begin
            // Watchdog leaves the undervoltage flag alone
            next_s.seq = supervisor_pkg::SEQ_WDG_PULSE;
            next_s.count = WDG_LOAD;
            next_s.wdg_flag = 1'b1;
            next_s.evt_status[supervisor_pkg::EVT_WDG] = 1'b1;
          end else if (!reset_line_in) begin
            // Line pulled by someone else; no cause flag changes
            next_s.seq = supervisor_pkg::SEQ_EXT_HOLD;
          end
        end
        supervisor_pkg::SEQ_WDG_PULSE: begin
          if (s.count == '0) begin
            next_s.seq = supervisor_pkg::SEQ_DELAY;
            next_s.count = delay_load;
          end else begin
            next_s.count = s.count - 1'b1;
          end
        end
        supervisor_pkg::SEQ_UV_HOLD: begin
          // Stays while the supply is low
          if (!(uv_detector_enable && uv_comparator)) begin
            next_s.seq = supervisor_pkg::SEQ_DELAY;
            next_s.count = delay_load;
          end
        end
        supervisor_pkg::SEQ_EXT_HOLD: begin
          if (reset_line_in) begin
            next_s.seq = supervisor_pkg::SEQ_DELAY;
            next_s.count = delay_load;
          end
        end
        supervisor_pkg::SEQ_DELAY: begin
          if (s.count == '0) begin
            next_s.seq = supervisor_pkg::SEQ_IDLE;
          end else begin
            next_s.count = s.count - 1'b1;
          end
        end
      endcase
    end

    // Register contents frozen in halt; detector keeps sampling
    if (!halt_mode) begin
      next_s.pll_lock = pll_locked;
      // Warning flag only exists with the undervoltage detector on
      next_s.warn_flag = uv_detector_enable & s.warn_sync2;
      if (uv_detector_enable && s.warn_sync2 && !s.warn_flag) begin
        next_s.evt_status[supervisor_pkg::EVT_WARN] = 1'b1;
      end
    end

    // Pending warning request; a new rise wins over service entry
    if (warn_isr_enter) begin
      next_s.warn_pend = 1'b0;
    end
    if (!halt_mode && uv_detector_enable && s.irq_enable && s.warn_sync2 && !s.warn_flag) begin
      next_s.warn_pend = 1'b1;
    end

    // Write response handshake
    if (s.bvalid && bus_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = supervisor_pkg::RESP_OKAY;
      unique case (bus_req.awaddr)
        supervisor_pkg::OFS_CTRL_STATUS: begin
          // Halt ignores software writes; bits 7:5 are ignored anyway
          if (bus_req.wstrb[0] && !halt_mode) begin
            next_s.irq_enable = bus_req.wdata[supervisor_pkg::BIT_IRQ_ENABLE];
            // Write zero clears, unless the sequencer changes state this cycle
            if (!bus_req.wdata[supervisor_pkg::BIT_WDG_FLAG] &&
                next_s.seq == s.seq) begin
              next_s.wdg_flag = 1'b0;
            end
          end
        end
        supervisor_pkg::OFS_IRQ_STATUS: begin
          // Read-only; write accepted and dropped
        end
        supervisor_pkg::OFS_IRQ_MASK: begin
          if (bus_req.wstrb[0]) begin
            next_s.evt_mask = bus_req.wdata[supervisor_pkg::EVT_N-1:0];
          end
        end
        default: begin
          next_s.bresp = supervisor_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read data handshake
    if (s.rvalid && bus_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = supervisor_pkg::RESP_OKAY;
      next_s.rdata = 32'h0;
      unique case (bus_req.araddr)
        supervisor_pkg::OFS_CTRL_STATUS: begin
          next_s.rdata = {24'h0, csr_view};
          // Read clears the cause, unless a new one lands this cycle
          if (!halt_mode && !(next_s.seq == supervisor_pkg::SEQ_UV_HOLD &&
              s.seq != supervisor_pkg::SEQ_UV_HOLD)) begin
            next_s.uv_flag = 1'b0;
          end
        end
        supervisor_pkg::OFS_IRQ_STATUS: begin
          next_s.rdata = {29'h0, s.evt_status};
          // Cleared at the top, before this cycle's events are merged in
        end
        supervisor_pkg::OFS_IRQ_MASK: begin
          next_s.rdata = {29'h0, s.evt_mask};
        end
        default: begin
          next_s.rresp = supervisor_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
      s.seq <= supervisor_pkg::SEQ_IDLE;
      s.irq_enable <= supervisor_pkg::RST_IRQ_ENABLE;
      s.evt_mask <= supervisor_pkg::RST_IRQ_MASK;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open-drain line: only ever pulled low, enable marks the drive
  assign reset_line_out = 1'b0;
  assign reset_line_oe = (s.seq == supervisor_pkg::SEQ_WDG_PULSE) |
                         (s.seq == supervisor_pkg::SEQ_UV_HOLD) |
                         (s.seq == supervisor_pkg::SEQ_DELAY);
  assign core_reset = (s.seq != supervisor_pkg::SEQ_IDLE);

  // Warning threshold tracks the undervoltage level
  assign uv_threshold_sel = uv_level;
  assign warn_threshold_sel = uv_level;

  // CPU request only while interrupts are unmasked
  assign warn_irq_req = s.warn_pend & ~cpu_irq_masked;
  // Wake from wait only; halt is never left by a warning
  assign wait_wakeup = s.warn_pend & wait_mode & ~halt_mode;

  // Event interrupt: level while any unmasked sticky bit is set
  assign irq = |(s.evt_status & s.evt_mask);

  // Bus answers; ready terms are combinational
  assign bus_rsp.awready = wr_go;
  assign bus_rsp.wready = wr_go;
  assign bus_rsp.bvalid = s.bvalid;
  assign bus_rsp.bresp = s.bresp;
  assign bus_rsp.arready = rd_go;
  assign bus_rsp.rvalid = s.rvalid;
  assign bus_rsp.rdata = s.rdata;
  assign bus_rsp.rresp = s.rresp;

endmodule : reset_supply_supervisor

/* test/supervisor_checker.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port-level checks of the supply and reset supervisor
// ****************************************************************
module supervisor_checker #(
  parameter int WDG_PULSE_CYCLES = 4,
  parameter int DELAY_SHORT = 4,
  parameter int DELAY_LONG = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire supervisor_pkg::axil_req_t bus_req,
  input wire supervisor_pkg::axil_rsp_t bus_rsp,
  // Options and sources
  input wire logic uv_detector_enable,
  input wire supervisor_pkg::threshold_level_t uv_level,
  input wire logic wdg_underflow,
  input wire logic uv_comparator,
  input wire logic cpu_irq_masked,
  input wire logic halt_mode,
  // Observed line and outputs
  input wire logic reset_line_in,
  input wire logic reset_line_out,
  input wire logic reset_line_oe,
  input wire logic core_reset,
  input wire supervisor_pkg::threshold_level_t uv_threshold_sel,
  input wire supervisor_pkg::threshold_level_t warn_threshold_sel,
  input wire logic warn_irq_req,
  input wire logic wait_wakeup
);
  logic uv_act; // Undervoltage cause present
  logic [15:0] oe_len; // Cycles of the current line drive
  assign uv_act = uv_detector_enable && uv_comparator;
  // Run length of the drive; a clipped delay phase shows up here
  always_ff @(posedge clk) begin
    oe_len <= (!rst_b || !reset_line_oe) ? 16'h0 : oe_len + 16'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wdg_pulse_a: assert property (!core_reset && wdg_underflow && reset_line_in && !uv_act
    |=> reset_line_oe [*8]) else $error("watchdog pulse too short");
  uv_hold_a: assert property (uv_act |=> reset_line_oe && core_reset)
    else $error("undervoltage not holding line");
  delay_len_a: assert property ($fell(reset_line_oe) |-> oe_len >= 16'(DELAY_SHORT))
    else $error("delay phase cut short");
  ext_hold_a: assert property (!core_reset && !reset_line_in && !uv_act && !wdg_underflow
    |=> core_reset && !reset_line_oe) else $error("external hold wrong");
  drive_low_a: assert property (reset_line_oe |-> core_reset && !reset_line_out)
    else $error("line drive outside reset");
  thresh_sel_a: assert property (uv_threshold_sel == uv_level && warn_threshold_sel == uv_level)
    else $error("threshold select mismatch");
  masked_req_a: assert property (cpu_irq_masked |-> !warn_irq_req)
    else $error("request while masked");
  halt_wake_a: assert property (halt_mode |-> !wait_wakeup)
    else $error("wakeup during halt");
  wr_answer_a: assert property (bus_req.awvalid && bus_req.wvalid && !bus_rsp.bvalid
    |=> bus_rsp.bvalid) else $error("write not answered");
  rd_answer_a: assert property (bus_req.arvalid && !bus_rsp.rvalid |=> bus_rsp.rvalid)
    else $error("read not answered");
  // Main scenarios reached
  cover property (!core_reset && wdg_underflow);
  cover property (uv_act && reset_line_oe);
  cover property (!reset_line_in && core_reset && !reset_line_oe);
  cover property ($rose(warn_irq_req));
endmodule : supervisor_checker

bind reset_supply_supervisor supervisor_checker #(.WDG_PULSE_CYCLES(WDG_PULSE_CYCLES),
  .DELAY_SHORT(DELAY_SHORT), .DELAY_LONG(DELAY_LONG)) supervisor_checker_i (
  .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .uv_detector_enable(uv_detector_enable), .uv_level(uv_level),
  .wdg_underflow(wdg_underflow), .uv_comparator(uv_comparator),
  .cpu_irq_masked(cpu_irq_masked), .halt_mode(halt_mode), .reset_line_in(reset_line_in),
  .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe), .core_reset(core_reset),
  .uv_threshold_sel(uv_threshold_sel), .warn_threshold_sel(warn_threshold_sel),
  .warn_irq_req(warn_irq_req), .wait_wakeup(wait_wakeup));

/* test/reset_line_party.sv */
`timescale 1ns/1ps
// ****************************************************************
// Other parties on the shared open-drain reset line
// ****************************************************************
module reset_line_party (
  // Supervisor drive
  input wire logic drive_oe,
  input wire logic drive_out,
  // External circuit pulling low
  input wire logic ext_pull,
  // Resolved level
  output logic line
);
  // Pull-up wins unless a party pulls low; a released line reads high
  assign line = !((drive_oe && !drive_out) || ext_pull);
endmodule : reset_line_party

/* test/reset_supply_supervisor_test.sv */
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the supply and reset supervisor
// ****************************************************************
module reset_supply_supervisor_test;
  logic clk = 1'b0; // 20 MHz clock
  logic rst_b = 1'b0; // Active-low reset
  supervisor_pkg::axil_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0}; // Ready held up
  supervisor_pkg::axil_rsp_t rsp; // Bus answer
  supervisor_pkg::threshold_level_t level = supervisor_pkg::LEVEL_LOW; // Threshold option
  supervisor_pkg::threshold_level_t uv_sel, warn_sel; // Threshold outputs
  logic uv_en = 1'b1, xtal = 1'b0, wdg = 1'b0, uvc = 1'b0, warn_c = 1'b0, pll = 1'b0;
  logic masked = 1'b1, isr = 1'b0, wait_m = 1'b0, halt_m = 1'b0, ext_pull = 1'b0;
  logic line, line_out, oe, core_rst, irq_req, wake, irq; // Observed
  logic [31:0] rd; // Last read data
  logic [1:0] rr, br; // Last read and write responses
  int mismatches = 0, check_count = 0, n, c;
  always #25 clk = ~clk;
  // Short counts keep the run brief: pulse 4, delays 4 and 8
  reset_supply_supervisor #(.WDG_PULSE_CYCLES(4), .DELAY_SHORT(4), .DELAY_LONG(8))
    reset_supply_supervisor_i (.clk(clk), .rst_b(rst_b), .bus_req(req), .bus_rsp(rsp),
    .uv_detector_enable(uv_en), .uv_level(level), .crystal_clock_source(xtal),
    .wdg_underflow(wdg), .uv_comparator(uvc), .warn_comparator_async(warn_c),
    .pll_locked(pll), .reset_line_in(line), .reset_line_out(line_out),
    .reset_line_oe(oe), .core_reset(core_rst), .uv_threshold_sel(uv_sel),
    .warn_threshold_sel(warn_sel), .cpu_irq_masked(masked), .warn_isr_enter(isr),
    .wait_mode(wait_m), .halt_mode(halt_m), .warn_irq_req(irq_req),
    .wait_wakeup(wake), .irq(irq));
  reset_line_party reset_line_party_i (.drive_oe(oe), .drive_out(line_out),
    .ext_pull(ext_pull), .line(line));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // One edge; values read here are those sampled at the edge
  task automatic tick();
    @(posedge clk);
    n++;
    if (n > 300) begin
      mismatches++;
      wrap_up();
    end
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    n = 0;
    do tick(); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do tick(); while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    n = 0;
    do tick(); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do tick(); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask : rdr
  // Sources set by the caller are dropped after k edges; counts drive cycles
  task automatic run_oe(input int k);
    n = 0;
    c = 0;
    repeat (k) begin
      tick();
      c += int'(oe === 1'b1);
    end
    wdg <= 1'b0;
    uvc <= 1'b0;
    ext_pull <= 1'b0;
    do begin
      tick();
      c += int'(oe === 1'b1);
    end while (oe === 1'b1 || c == 0);
  endtask : run_oe
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rdr(4'h0);
    chk("ctrl reset", rd, 32'h0);
    pll <= 1'b1;
    rdr(4'h8);
    chk("mask reset", rd, 32'h0);
    rdr(4'h0);
    chk("lock set", rd, 32'h8);
    wr(4'h0, 32'h1);
    rdr(4'h0);
    chk("enable set", rd, 32'h9);
    wr(4'h0, 32'h0);
    chk("write resp", br, 2'h0);
    rdr(4'hc);
    chk("unmapped resp", rr, 2'h2);
    chk("unmapped data", rd, 32'h0);
    wr(4'hc, 32'h0);
    chk("unmapped wr resp", br, 2'h2);
    for (int i = 0; i < 3; i++) begin
      level <= supervisor_pkg::threshold_level_t'(i);
      @(posedge clk);
      @(posedge clk);
      chk("uv threshold", uv_sel, i);
      chk("warn threshold", warn_sel, i);
    end
  endtask : t_regs
  task automatic t_resets();
    wr(4'h8, 32'h7);
    wdg <= 1'b1;
    run_oe(1);
    chk("wdg drive", c, 8);
    chk("event irq", irq, 1'b1);
    rdr(4'h0);
    chk("wdg cause", rd, 32'h18);
    rdr(4'h4);
    chk("wdg event", rd, 32'h1);
    chk("irq cleared", irq, 1'b0);
    wr(4'h0, 32'h0);
    rdr(4'h0);
    chk("wdg write zero", rd, 32'h8);
    wdg <= 1'b1;
    run_oe(1);
    xtal <= 1'b1;
    uvc <= 1'b1;
    run_oe(5);
    chk("uv drive", c, 13);
    rdr(4'h0);
    chk("uv cause", rd, 32'hc);
    rdr(4'h0);
    chk("uv read clear", rd, 32'h8);
    uvc <= 1'b1;
    run_oe(3);
    xtal <= 1'b0;
    wdg <= 1'b1;
    run_oe(1);
    ext_pull <= 1'b1;
    run_oe(3);
    chk("ext drive", c, 4);
    rdr(4'h0);
    chk("uv kept", rd, 32'h1c);
    rdr(4'h4);
    chk("events", rd, 32'h3);
  endtask : t_resets
  task automatic t_warn();
    wr(4'h0, 32'h11);
    wr(4'h8, 32'h4);
    warn_c <= 1'b1;
    repeat (4) @(posedge clk);
    chk("req masked", irq_req, 1'b0);
    masked <= 1'b0;
    wait_m <= 1'b1;
    repeat (2) @(posedge clk);
    chk("req unmasked", irq_req, 1'b1);
    chk("wait wake", wake, 1'b1);
    isr <= 1'b1;
    @(posedge clk);
    isr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("isr clears", irq_req, 1'b0);
    rdr(4'h4);
    chk("warn event", rd, 32'h4);
    rdr(4'h0);
    chk("warn flag", rd, 32'h1b);
    halt_m <= 1'b1;
    warn_c <= 1'b0;
    repeat (4) @(posedge clk);
    rdr(4'h0);
    chk("halt frozen", rd, 32'h1b);
    halt_m <= 1'b0;
    repeat (4) @(posedge clk);
    rdr(4'h0);
    chk("flag follows", rd, 32'h19);
    uv_en <= 1'b0;
    warn_c <= 1'b1;
    uvc <= 1'b1;
    repeat (4) @(posedge clk);
    chk("uv off line", oe, 1'b0);
    rdr(4'h0);
    chk("warn off", rd, 32'h19);
    chk("warn off req", irq_req, 1'b0);
    uvc <= 1'b0;
  endtask : t_warn
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_resets();
    t_warn();
    uv_en <= 1'b1;
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("oe after reset", oe, 1'b0);
    rdr(4'h0);
    chk("flags after reset", rd, 32'h8);
    wrap_up();
  end
endmodule : reset_supply_supervisor_test
